/* File: hw/bms_ctrl.sv */
// boot mode sequencer with status indicators and axi4-lite register slave
`timescale 1ns/1ps
// Functional notes
// - power indicator lights immediately at power-up
// - ready flashes during self test and addressing
// - self test lasts about ten seconds
// - ready steady once tested and addressed
// - all switches off means normal operation
// - switch 8 runs extended loopback factory tests
// - switch 7 alone permits firmware reprogramming; the code enables it on switch 7 whatever the other switches
// - firmware update done shows slow flashing
// - switch 6 off: network address, stored
// - switch 6 on: load stored address
// - switch 6 on ignores switch 5
// - repeat rarp requests until valid reply
// - switch 5 on: no rarp, wait manual
// - fast flashing when no address obtainable
// - error code long flashes one second
// - error code short flashes fifth second
// - three seconds dark between code repeats
module bms_ctrl
    import bms_pkg::*;
#(
    parameter int unsigned SELFTEST = SELFTEST_CYC,
    parameter int unsigned RARP_RETRY = RARP_CYC,
    parameter int unsigned LONG = LONG_CYC,
    parameter int unsigned SHORT = SHORT_CYC,
    parameter int unsigned GAP = GAP_CYC,
    parameter int unsigned FLASH = FLASH_CYC,
    parameter int unsigned FAST = FAST_CYC,
    parameter int unsigned SLOW = SLOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] dip_sw,
    input wire logic loopback_ok,
    input wire logic rarp_reply_valid,
    input wire logic [31:0] rarp_reply_ip,
    input wire logic [31:0] nv_ip,
    output logic nv_ip_we,
    output logic [31:0] nv_ip_wdata,
    output logic rarp_req,
    output logic fw_write_en,
    output logic ext_test,
    output logic power_led,
    output logic ready_led,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ----------------------------------------------------------------
    // switch capture
    // ----------------------------------------------------------------
    logic [7:0] sw_sync;
    logic [7:0] sw_q;
    logic sampled_q;
    logic lb_sync;
    logic [1:0] lb_meta;

    bms_sync #(.W(8)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .en(ce),
        .din(dip_sw),
        .dout(sw_sync)
    );

    // first synchronised sample is held
    logic [1:0] fill_q;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sw_q <= '0;
            sampled_q <= 1'b0;
            fill_q <= '0;
            lb_meta <= '0;
        end else if (ce) begin
            lb_meta <= {lb_meta[0], loopback_ok};
            if (fill_q != 2'h2) begin
                fill_q <= fill_q + 2'h1;
            end else if (!sampled_q) begin
                sw_q <= sw_sync;
                sampled_q <= 1'b1;
            end
        end
    end
    assign lb_sync = lb_meta[1];

    wire sw_manual = sw_q[SW_MANUAL];
    wire sw_stored = sw_q[SW_STORED];
    wire sw_modify = sw_q[SW_MODIFY];
    wire sw_xtest = sw_q[SW_XTEST];
    // switch 5 counts only for network addressing
    wire use_rarp = !sw_stored && !sw_manual;
    wire use_manual = !sw_stored && sw_manual;

    assign ext_test = sampled_q && sw_xtest;
    assign fw_write_en = sampled_q && sw_modify;
    assign power_led = 1'b1;

    // ----------------------------------------------------------------
    // register bus decode
    // ----------------------------------------------------------------
    logic aw_q;
    logic w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic bvalid_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] bresp_q;
    logic [1:0] rresp_q;
    logic [IRQ_W-1:0] istat_q;
    logic [IRQ_W-1:0] imask_q;
    logic [3:0] err_long_q;
    logic [3:0] err_short_q;
    logic [31:0] ip_q;

    wire do_wr = aw_q && w_q && !bvalid_q;
    wire wr_ctrl = do_wr && (awaddr_q == A_CTRL);
    wire wr_istat = do_wr && (awaddr_q == A_IRQ_STAT);
    wire wr_imask = do_wr && (awaddr_q == A_IRQ_MASK);
    wire wr_err = do_wr && (awaddr_q == A_ERRCODE);
    wire wr_ok = wr_ctrl || wr_istat || wr_imask || wr_err;
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire cmd_pass = wr_ctrl && wdata_q[C_TEST_PASS];
    wire cmd_fail = wr_ctrl && wdata_q[C_TEST_FAIL];
    wire cmd_manual = wr_ctrl && wdata_q[C_MANUAL_IP];
    wire cmd_fwdone = wr_ctrl && wdata_q[C_FW_DONE] && fw_write_en;
    wire cmd_noaddr = wr_ctrl && wdata_q[C_NOADDR];

    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    bms_state_t st_q;
    logic [31:0] tmr_q;
    logic [31:0] rtmr_q;
    logic rarp_q;
    logic we_q;
    logic [31:0] wip_q;
    bms_led_t led_mode;

    wire st_done = (tmr_q + 32'h1 >= SELFTEST);
    wire rarp_due = (rtmr_q + 32'h1 >= RARP_RETRY);
    wire in_addr = (st_q == ST_ADDR);
    wire ev_ready = in_addr && ((sw_stored) || (use_rarp && rarp_reply_valid) ||
                                (use_manual && cmd_manual));

    assign rarp_req = rarp_q;
    assign nv_ip_we = we_q;
    assign nv_ip_wdata = wip_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q <= ST_SELFTEST;
            tmr_q <= '0;
            rtmr_q <= '0;
            rarp_q <= 1'b0;
            we_q <= 1'b0;
            wip_q <= '0;
            ip_q <= '0;
        end else if (ce) begin
            rarp_q <= 1'b0;
            we_q <= 1'b0;
            unique case (st_q)
                ST_SELFTEST: begin
                    if (sampled_q) begin
                        tmr_q <= st_done ? tmr_q : tmr_q + 32'h1;
                        if (st_done) begin
                            st_q <= ST_TESTWAIT;
                        end
                    end
                end
                ST_TESTWAIT: begin
                    // extended tests fail unless the loopback fixture answers
                    if (cmd_fail || (sw_xtest && !lb_sync)) begin
                        st_q <= ST_ERROR;
                    end else if (cmd_pass) begin
                        st_q <= ST_ADDR;
                        rtmr_q <= RARP_RETRY - 32'h1;
                    end
                end
                ST_ADDR: begin
                    if (sw_stored) begin
                        ip_q <= nv_ip;
                        st_q <= ST_READY;
                    end else if (use_rarp && rarp_reply_valid) begin
                        ip_q <= rarp_reply_ip;
                        wip_q <= rarp_reply_ip;
                        we_q <= 1'b1;
                        st_q <= ST_READY;
                    end else if (use_manual && cmd_manual) begin
                        ip_q <= wdata_q;
                        wip_q <= wdata_q;
                        we_q <= 1'b1;
                        st_q <= ST_READY;
                    end else if (cmd_noaddr) begin
                        st_q <= ST_NOADDR;
                    end else if (use_rarp) begin
                        rtmr_q <= rarp_due ? '0 : rtmr_q + 32'h1;
                        rarp_q <= rarp_due;
                    end
                end
                ST_NOADDR: begin
                    // keep trying in the background while signalling
                    if (use_rarp && rarp_reply_valid) begin
                        ip_q <= rarp_reply_ip;
                        wip_q <= rarp_reply_ip;
                        we_q <= 1'b1;
                        st_q <= ST_READY;
                    end else if (use_rarp) begin
                        rtmr_q <= rarp_due ? '0 : rtmr_q + 32'h1;
                        rarp_q <= rarp_due;
                    end
                end
                ST_READY: begin
                    if (cmd_fail) begin
                        st_q <= ST_ERROR;
                    end else if (cmd_fwdone) begin
                        st_q <= ST_FWDONE;
                    end
                end
                ST_ERROR, ST_FWDONE: st_q <= st_q;
                default: st_q <= ST_ERROR;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // ready indicator
    // ----------------------------------------------------------------
    assign led_mode = (st_q == ST_READY) ? LED_ON :
                      (st_q == ST_NOADDR) ? LED_FAST :
                      (st_q == ST_ERROR) ? LED_CODE :
                      (st_q == ST_FWDONE) ? LED_SLOW :
                      LED_FLASH;

    bms_led #(
        .LONG(LONG),
        .SHORT(SHORT),
        .GAP(GAP),
        .FLASH(FLASH),
        .FAST(FAST),
        .SLOW(SLOW)
    ) u_led (
        .clk(clk),
        .nrst(nrst),
        .en(ce),
        .mode(led_mode),
        .n_long(err_long_q),
        .n_short(err_short_q),
        .led(ready_led)
    );

    // ----------------------------------------------------------------
    // interrupts and bus registers
    // ----------------------------------------------------------------
    logic [IRQ_W-1:0] ev;
    assign ev[IRQ_READY] = ev_ready;
    assign ev[IRQ_ERROR] = (st_q != ST_ERROR) && (cmd_fail ||
                           (st_q == ST_TESTWAIT && sw_xtest && !lb_sync));
    assign ev[IRQ_NOADDR] = in_addr && cmd_noaddr && !ev_ready;
    assign ev[IRQ_FWDONE] = (st_q == ST_READY) && cmd_fwdone && !cmd_fail;
    assign irq = |(istat_q & imask_q);

    wire [IRQ_W-1:0] iclr = wr_istat ? wdata_q[IRQ_W-1:0] : '0;
    wire [31:0] status_word = {20'h0, sw_q, sampled_q, st_q};
    wire [31:0] rd_mux = (s_axi_araddr == A_STATUS) ? status_word :
                         (s_axi_araddr == A_IRQ_STAT) ? {28'h0, istat_q} :
                         (s_axi_araddr == A_IRQ_MASK) ? {28'h0, imask_q} :
                         (s_axi_araddr == A_IP) ? ip_q :
                         (s_axi_araddr == A_ERRCODE) ? {24'h0, err_short_q, err_long_q} :
                         32'h0;
    wire rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= A_ERRCODE);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
            istat_q <= '0;
            imask_q <= '0;
            err_long_q <= 4'h1;
            err_short_q <= 4'h1;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_q) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_q) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                aw_q <= 1'b0;
                w_q <= 1'b0;
            end
            if (rd_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
            // a new event outranks a simultaneous clear
            istat_q <= (istat_q & ~iclr) | ev;
            if (wr_imask) begin
                imask_q <= wdata_q[IRQ_W-1:0];
            end
            if (wr_err) begin
                err_long_q <= wdata_q[3:0];
                err_short_q <= wdata_q[7:4];
            end
        end
    end
endmodule : bms_ctrl

/* File: hw/bms_pkg.sv */
// constants of the boot sequencer
package bms_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CYC_MS = CLK_HZ / 1000;
    localparam int unsigned SELFTEST_CYC = 10_000 * CYC_MS;
    localparam int unsigned LONG_CYC = 1000 * CYC_MS;
    localparam int unsigned SHORT_CYC = 200 * CYC_MS;
    localparam int unsigned GAP_CYC = 3000 * CYC_MS;
    localparam int unsigned FLASH_CYC = 500 * CYC_MS;
    localparam int unsigned FAST_CYC = 100 * CYC_MS;
    localparam int unsigned SLOW_CYC = 1500 * CYC_MS;
    localparam int unsigned RARP_CYC = 2000 * CYC_MS;

    // switch n sits at bit n-1
    localparam int unsigned SW_MANUAL = 4;
    localparam int unsigned SW_STORED = 5;
    localparam int unsigned SW_MODIFY = 6;
    localparam int unsigned SW_XTEST = 7;

    // axi register byte addresses
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_IRQ_STAT = 8'h04;
    localparam logic [7:0] A_IRQ_MASK = 8'h08;
    localparam logic [7:0] A_CTRL = 8'h0C;
    localparam logic [7:0] A_IP = 8'h10;
    localparam logic [7:0] A_ERRCODE = 8'h14;

    // irq status bits
    localparam int unsigned IRQ_READY = 0;
    localparam int unsigned IRQ_ERROR = 1;
    localparam int unsigned IRQ_NOADDR = 2;
    localparam int unsigned IRQ_FWDONE = 3;
    localparam int unsigned IRQ_W = 4;

    // ctrl bits pulse on write one
    localparam int unsigned C_TEST_PASS = 0;
    localparam int unsigned C_TEST_FAIL = 1;
    localparam int unsigned C_MANUAL_IP = 2;
    localparam int unsigned C_FW_DONE = 3;
    localparam int unsigned C_NOADDR = 4;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_SELFTEST = 3'h0,
        ST_TESTWAIT = 3'h1,
        ST_ADDR = 3'h2,
        ST_READY = 3'h3,
        ST_NOADDR = 3'h4,
        ST_ERROR = 3'h5,
        ST_FWDONE = 3'h6
    } bms_state_t;

    typedef enum logic [2:0] {
        LED_OFF = 3'h0,
        LED_ON = 3'h1,
        LED_FLASH = 3'h2,
        LED_FAST = 3'h3,
        LED_SLOW = 3'h4,
        LED_CODE = 3'h5
    } bms_led_t;

endpackage : bms_pkg

/* File: hw/bms_sync.sv */
// two flip-flop synchroniser for a vector of slow pins
`timescale 1ns/1ps
module bms_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_q <= '0;
            dout <= '0;
        end else if (en) begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : bms_sync

/* File: hw/bms_led.sv */
// ready indicator pattern generator
`timescale 1ns/1ps
module bms_led
    import bms_pkg::*;
#(
    parameter int unsigned LONG = LONG_CYC,
    parameter int unsigned SHORT = SHORT_CYC,
    parameter int unsigned GAP = GAP_CYC,
    parameter int unsigned FLASH = FLASH_CYC,
    parameter int unsigned FAST = FAST_CYC,
    parameter int unsigned SLOW = SLOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    input wire bms_led_t mode,
    input wire logic [3:0] n_long,
    input wire logic [3:0] n_short,
    output logic led
);
    logic [31:0] cnt_q;
    logic [4:0] ph_q;
    logic [3:0] left_q;
    logic led_q;
    bms_led_t mode_q;
    logic [31:0] half;
    logic code_long;
    logic expire;

    // error code phases: 0 = long on/off, 1 = short on/off, 2 = gap
    assign code_long = (ph_q[4:3] == 2'h0);
    assign half = (mode == LED_FLASH) ? FLASH :
                  (mode == LED_FAST) ? FAST :
                  (mode == LED_SLOW) ? SLOW :
                  (ph_q[4:3] == 2'h2) ? GAP :
                  code_long ? LONG : SHORT;
    assign expire = (cnt_q + 32'h1 >= half);
    assign led = led_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q <= '0;
            ph_q <= '0;
            left_q <= '0;
            led_q <= 1'b0;
            mode_q <= LED_OFF;
        end else if (en) begin
            mode_q <= mode;
            if (mode != mode_q) begin
                cnt_q <= '0;
                ph_q <= '0;
                left_q <= (n_long == 4'h0) ? 4'h1 : n_long;
                led_q <= (mode != LED_OFF);
            end else if (mode == LED_ON) begin
                led_q <= 1'b1;
            end else if (mode == LED_OFF) begin
                led_q <= 1'b0;
            end else if (expire) begin
                cnt_q <= '0;
                if (mode != LED_CODE) begin
                    led_q <= !led_q;
                end else if (ph_q[4:3] == 2'h2) begin
                    ph_q <= '0;
                    left_q <= (n_long == 4'h0) ? 4'h1 : n_long;
                    led_q <= 1'b1;
                end else if (led_q) begin
                    led_q <= 1'b0;
                end else if (left_q > 4'h1) begin
                    left_q <= left_q - 4'h1;
                    led_q <= 1'b1;
                end else if (code_long) begin
                    ph_q <= 5'h08;
                    left_q <= (n_short == 4'h0) ? 4'h1 : n_short;
                    led_q <= 1'b1;
                end else begin
                    ph_q <= 5'h10;
                    led_q <= 1'b0;
                end
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule : bms_led

/* File: tb/bms_rarp_srv.sv */
// rarp server model, fixed reply delay
`timescale 1ns/1ps
module bms_rarp_srv #(
    parameter int DLY = 3
) (
    input wire logic clk,
    input wire logic en,
    input wire logic [31:0] ip,
    input wire logic req,
    output logic vld,
    output logic [31:0] ip_o
);
    int cnt = 0;
    initial vld = 1'b0;
    initial ip_o = 32'h0;
    // address lines wander between replies
    always @(posedge clk) begin
        vld <= 1'b0;
        ip_o <= ~ip_o;
        if (req && en) cnt <= DLY;
        else if (cnt > 0) cnt <= cnt - 1;
        if (cnt == 1) begin
            vld <= 1'b1;
            ip_o <= ip;
        end
    end
endmodule : bms_rarp_srv

/* File: tb/bms_ctrl_asserts.sv */
// port checker for the boot sequencer
`timescale 1ns/1ps
module bms_ctrl_asserts
    import bms_pkg::*;
#(
    parameter int unsigned SELFTEST = 20,
    parameter int unsigned RARP_RETRY = 10,
    parameter int unsigned FLASH = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] dip_sw,
    input wire logic rarp_reply_valid,
    input wire logic [31:0] rarp_reply_ip,
    input wire logic nv_ip_we,
    input wire logic [31:0] nv_ip_wdata,
    input wire logic rarp_req,
    input wire logic fw_write_en,
    input wire logic ext_test,
    input wire logic power_led,
    input wire logic ready_led,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    localparam int FL = FLASH + 1;
    logic [15:0] age_q;
    logic [15:0] gap_q;
    logic wait_q;
    logic [7:0] sw_q;
    logic [31:0] ip_q;
    // switches as held in reset
    always_ff @(posedge clk) begin
        sw_q <= nrst ? sw_q : dip_sw;
        age_q <= !nrst ? 16'h0 : age_q + {15'h0, age_q != 16'hFFFF};
        wait_q <= nrst && (rarp_req || (wait_q && !rarp_reply_valid));
        gap_q <= (!nrst || rarp_req) ? 16'h0 : gap_q + {15'h0, wait_q};
        ip_q <= rarp_reply_valid ? rarp_reply_ip : ip_q;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_reply;
        rarp_reply_valid && wait_q;
    endsequence
    property p_pwr; power_led; endproperty
    a_pwr: assert property (p_pwr) else $error("power lamp dark");
    property p_st; age_q < SELFTEST |-> !rarp_req && !nv_ip_we; endproperty
    a_st: assert property (p_st) else $error("addressing during self test");
    property p_flash; age_q > 4 && age_q < SELFTEST |-> ##[0:FL] !$stable(ready_led); endproperty
    a_flash: assert property (p_flash) else $error("ready lamp not flashing");
    property p_retry; wait_q |-> gap_q <= RARP_RETRY + 1; endproperty
    a_retry: assert property (p_retry) else $error("request not repeated");
    property p_norarp; sw_q[SW_MANUAL] || sw_q[SW_STORED] |-> !rarp_req; endproperty
    a_norarp: assert property (p_norarp) else $error("unwanted request");
    property p_nvwe; s_reply |-> ##[1:3] nv_ip_we; endproperty
    a_nvwe: assert property (p_nvwe) else $error("reply not stored");
    property p_nvdat;
        nv_ip_we && !sw_q[SW_MANUAL] && !sw_q[SW_STORED] |-> nv_ip_wdata == ip_q;
    endproperty
    a_nvdat: assert property (p_nvdat) else $error("stored address wrong");
    property p_fw;
        age_q > 8 |-> fw_write_en == sw_q[SW_MODIFY] && ext_test == sw_q[SW_XTEST];
    endproperty
    a_fw: assert property (p_fw) else $error("mode outputs off switches");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule : bms_ctrl_asserts
bind bms_ctrl bms_ctrl_asserts #(.SELFTEST(SELFTEST), .RARP_RETRY(RARP_RETRY), .FLASH(FLASH))
    u_chk (.clk(clk), .nrst(nrst), .dip_sw(dip_sw), .rarp_reply_valid(rarp_reply_valid),
    .rarp_reply_ip(rarp_reply_ip), .nv_ip_we(nv_ip_we), .nv_ip_wdata(nv_ip_wdata),
    .rarp_req(rarp_req), .fw_write_en(fw_write_en), .ext_test(ext_test),
    .power_led(power_led), .ready_led(ready_led), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready));

/* File: tb/bms_ctrl_tb_top.sv */
// self-checking bench for the boot sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module bms_ctrl_tb_top
    import bms_pkg::*;
;
    localparam int ST = 20, RT = 10, LG = 8, SH = 4, GP = 12, FS = 3, FT = 2, SL = 6;
    localparam logic [31:0] SRV = 32'hC0A80117, NV = 32'h0A0B0C0D, MAN = 32'h0A000A04;
    logic clk = 0, nrst = 0, ce = 1, lb = 0, srv_en = 0, vld;
    logic [7:0] sw = 8'h00, awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rip, nvwd, rdat, rd;
    logic nvwe, req, fwe, ext, pwr, rdy, irq, awr, wr, bv, arr, rv;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic [1:0] bresp, rresp, rr;
    int num_errors = 0, n_checks = 0, n_req = 0;
    always #25 clk = ~clk;
    always @(posedge clk) n_req <= n_req + int'(req);
    bms_ctrl #(.SELFTEST(ST), .RARP_RETRY(RT), .LONG(LG), .SHORT(SH), .GAP(GP),
        .FLASH(FS), .FAST(FT), .SLOW(SL)) u_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .dip_sw(sw), .loopback_ok(lb),
        .rarp_reply_valid(vld), .rarp_reply_ip(rip), .nv_ip(NV), .nv_ip_we(nvwe),
        .nv_ip_wdata(nvwd), .rarp_req(req), .fw_write_en(fwe), .ext_test(ext),
        .power_led(pwr), .ready_led(rdy), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rre));
    bms_rarp_srv #(.DLY(3)) u_srv (.clk(clk), .en(srv_en), .ip(SRV), .req(req),
        .vld(vld), .ip_o(rip));
    function automatic logic [31:0] stv(input logic [7:0] w, input logic [2:0] s);
        return {20'h0, w, 1'b1, s};
    endfunction : stv
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    // an idle edge ends each access
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        for (int t = 0; t < 99; t++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) break;
        end
        `CHK(bresp, er)
        bre <= 1'b0;
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [7:0] a);
        araddr <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        for (int t = 0; t < 99; t++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rd = rdat;
        rr = rresp;
        rre <= 1'b0;
        @(posedge clk);
    endtask : axr
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        axr(a);
        `CHK(rd, e)
        `CHK(rr, er)
    endtask : rc
    task automatic sc(input logic [7:0] w, input logic [2:0] s);
        for (int i = 0; i < 60; i++) begin
            axr(A_STATUS);
            if (rd[2:0] === s) break;
        end
        rc(A_STATUS, stv(w, s), RESP_OKAY);
    endtask : sc
    task automatic boot(input logic [7:0] s);
        nrst <= 1'b0;
        sw <= s;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : boot
    task automatic pass(input logic [7:0] w);
        sc(w, ST_TESTWAIT);
        axw(A_CTRL, 32'h1, RESP_OKAY);
    endtask : pass
    task automatic run(input logic lvl, output int n);
        n = 0;
        for (int i = 0; i < 200 && rdy !== lvl; i++) @(posedge clk);
        while (rdy === lvl && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask : run
    initial begin
        #(50 * 20000);
        num_errors++;
        wrap_up;
    end
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        int n;
        int r0;
        boot(8'h00);
        rc(A_STATUS, stv(8'h00, ST_SELFTEST), RESP_OKAY);
        rc(A_IRQ_STAT, 32'h0, RESP_OKAY);
        rc(A_IRQ_MASK, 32'h0, RESP_OKAY);
        rc(A_ERRCODE, 32'h11, RESP_OKAY);
        rc(A_IP, 32'h0, RESP_OKAY);
        rc(8'h18, 32'h0, RESP_SLVERR);
        axw(8'h18, 32'hFFFFFFFF, RESP_SLVERR);
        sw <= 8'hC0;
        axw(A_IRQ_MASK, 32'hF, RESP_OKAY);
        r0 = n_req;
        pass(8'h00);
        for (int i = 0; i < 99 && n_req - r0 < 2; i++) @(posedge clk);
        `CHK(n_req - r0 >= 2, 1'b1)
        srv_en <= 1'b1;
        sc(8'h00, ST_READY);
        rc(A_IP, SRV, RESP_OKAY);
        rc(A_IRQ_STAT, 32'h1, RESP_OKAY);
        `CHK(irq, 1'b1)
        axw(A_IRQ_STAT, 32'h1, RESP_OKAY);
        `CHK(irq, 1'b0)
        n = 0;
        repeat (20) @(posedge clk) n += int'(rdy);
        `CHK(n, 20)
        axw(A_CTRL, 32'h8, RESP_OKAY);
        sc(8'h00, ST_READY);
        `CHK({pwr, fwe, ext}, 3'b100)
        boot(8'h30);
        r0 = n_req;
        pass(8'h30);
        sc(8'h30, ST_READY);
        rc(A_IP, NV, RESP_OKAY);
        `CHK(n_req - r0, 0)
        boot(8'h10);
        pass(8'h10);
        repeat (40) @(posedge clk);
        sc(8'h10, ST_ADDR);
        `CHK(n_req - r0, 0)
        axw(A_CTRL, MAN, RESP_OKAY);
        sc(8'h10, ST_READY);
        rc(A_IP, MAN, RESP_OKAY);
        boot(8'h10);
        pass(8'h10);
        axw(A_CTRL, 32'h10, RESP_OKAY);
        sc(8'h10, ST_NOADDR);
        rc(A_IRQ_STAT, 32'h4, RESP_OKAY);
        `CHK(irq, 1'b0)
        axw(A_IRQ_MASK, 32'h4, RESP_OKAY);
        `CHK(irq, 1'b1)
        run(1'b0, n);
        run(1'b1, n);
        `CHK(n, FT)
        boot(8'h40);
        pass(8'h40);
        sc(8'h40, ST_READY);
        `CHK(fwe, 1'b1)
        axw(A_CTRL, 32'h8, RESP_OKAY);
        sc(8'h40, ST_FWDONE);
        run(1'b0, n);
        run(1'b1, n);
        `CHK(n, SL)
        boot(8'h80);
        sc(8'h80, ST_ERROR);
        rc(A_IRQ_STAT, 32'h2, RESP_OKAY);
        `CHK(ext, 1'b1)
        n = 0;
        for (int i = 0; i < 10 && n < GP; i++) run(1'b0, n);
        `CHK(n >= GP, 1'b1)
        run(1'b1, n);
        `CHK(n, LG)
        run(1'b0, n);
        `CHK(n, LG)
        run(1'b1, n);
        `CHK(n, SH)
        wrap_up;
    end
endmodule : bms_ctrl_tb_top
